// file: hw/rstseq_pkg.sv
// Purpose: Shared constants, types and helpers of the reset and start-up sequencer
// Assumes: 10 MHz core clock; internal RC oscillator modelled as a clock divider
// Notes:   Register map is two 32-bit words on AXI4-Lite
package rstseq_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS    = 100;
  localparam int unsigned INTOSC_PERIOD_NS = 1000;
  localparam int unsigned INTOSC_DIV_CYCLES =
    (INTOSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INTOSC_DIV_W     = 4;
  localparam int unsigned PUD_TIME_MS      = 72;
  localparam int unsigned PUD_TICKS        = PUD_TIME_MS * 1000000 / INTOSC_PERIOD_NS;
  localparam int unsigned TIMER_W          = 20;
  localparam int unsigned OSU_CYCLES       = 1024;
  localparam int unsigned CLEAR_FILT_NS    = 500;
  localparam int unsigned CLEAR_FILT_CYCLES =
    (CLEAR_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BROWNOUT_MIN_NS  = 100000;
  localparam int unsigned BROWNOUT_MIN_CYCLES =
    (BROWNOUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILT_W           = 11;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int unsigned AXI_ADDR_W  = 4;
  localparam int unsigned AXI_DATA_W  = 32;
  localparam logic [3:0]  ADDR_CONFIG = 4'h0;
  localparam logic [3:0]  ADDR_STATUS = 4'h4;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  localparam int unsigned CFG_OSC_LSB    = 0;
  localparam int unsigned CFG_PUD_N_BIT  = 2;
  localparam int unsigned CFG_BOD_BIT    = 3;
  localparam logic [3:0]  CFG_RESET      = 4'hF;

  localparam int unsigned ST_WDX_BIT     = 0;
  localparam int unsigned ST_SLEEP_BIT   = 1;
  localparam int unsigned ST_POR_BIT     = 2;
  localparam int unsigned ST_BROWN_BIT   = 3;
  localparam int unsigned ST_CAUSE_LSB   = 4;
  localparam int unsigned ST_HOLD_BIT    = 7;
  localparam int unsigned ST_RESET_BIT   = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    OSC_LOW_POWER_CRYSTAL  = 2'h0,
    OSC_CRYSTAL            = 2'h1,
    OSC_HIGH_SPEED_CRYSTAL = 2'h2,
    OSC_RES_CAP            = 2'h3
  } rstseq_osc_t;

  typedef enum logic [2:0] {
    CAUSE_POWER_ON       = 3'h0,
    CAUSE_CLEAR_RUN      = 3'h1,
    CAUSE_CLEAR_SLEEP    = 3'h2,
    CAUSE_WATCHDOG_RESET = 3'h3,
    CAUSE_WATCHDOG_WAKE  = 3'h4,
    CAUSE_BROWNOUT       = 3'h5
  } rstseq_cause_t;

  typedef enum logic [2:0] {
    S_OFF      = 3'h0,
    S_BROWNOUT = 3'h1,
    S_PUD      = 3'h2,
    S_OSU      = 3'h3,
    S_RUN      = 3'h4,
    S_WAKE     = 3'h5
  } rstseq_state_t;

  typedef enum logic [1:0] {
    SEL_NONE   = 2'h0,
    SEL_CONFIG = 2'h1,
    SEL_STATUS = 2'h2
  } rstseq_sel_t;

  function automatic logic rstseq_is_crystal(input rstseq_osc_t mode);
    return mode != OSC_RES_CAP;
  endfunction

  function automatic rstseq_sel_t rstseq_decode(input logic [AXI_ADDR_W-1:0] addr);
    if (addr == ADDR_CONFIG)
      return SEL_CONFIG;
    else if (addr == ADDR_STATUS)
      return SEL_STATUS;
    else
      return SEL_NONE;
  endfunction

endpackage

// file: hw/rstseq_filter.sv
// Purpose: Level qualifier; output rises after the input stays high long enough
// Assumes: Input synchronous to aclk
// Notes:   Output drops on the first clock edge after the input drops
`timescale 1ns/1ps
`default_nettype none
module rstseq_filter
  import rstseq_pkg::*;
#(
  parameter int unsigned CYCLES = 1
)(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic raw,
  output var  logic filt_q
);

  logic [FILT_W-1:0] cnt_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !raw)
    begin
      cnt_q  <= '0;
      filt_q <= 1'b0;
    end
    else if (cnt_q == FILT_W'(CYCLES - 1))
      filt_q <= 1'b1;
    else
      cnt_q <= cnt_q + 1'b1;
  end

endmodule // rstseq_filter
`default_nettype wire

// file: hw/rstseq_timer.sv
// Purpose: One-shot delay counter stepped by an enable pulse
// Assumes: clear held while the timer is not in use
// Notes:   done_q holds until clear
`timescale 1ns/1ps
`default_nettype none
module rstseq_timer
  import rstseq_pkg::*;
#(
  parameter int unsigned LIMIT = 1
)(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic clear,
  input  wire logic step,
  output var  logic done_q
);

  logic [TIMER_W-1:0] cnt_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
    begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end
    else if (step && !done_q)
    begin
      if (cnt_q == TIMER_W'(LIMIT - 1))
        done_q <= 1'b1;
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule // rstseq_timer
`default_nettype wire

// file: hw/rstseq_top.sv
// Purpose: Reset cause tracking and power-up time-out sequencing
// Assumes: All pins synchronous to aclk; oscillator input sampled, edges counted
// Notes:   Registers: CONFIG at 0x0, STATUS at 0x4, AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
module rstseq_top
  import rstseq_pkg::*;
#(
  parameter int unsigned PUD_TICKS_P = PUD_TICKS
)(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output var  logic                  awready,
  input  wire logic [AXI_DATA_W-1:0] wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output var  logic                  wready,
  output var  logic [1:0]            bresp,
  output var  logic                  bvalid,
  input  wire logic                  bready,
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output var  logic                  arready,
  output var  logic [AXI_DATA_W-1:0] rdata,
  output var  logic [1:0]            rresp,
  output var  logic                  rvalid,
  input  wire logic                  rready,
  input  wire logic                  por_detect,
  input  wire logic                  brownout_below,
  input  wire logic                  master_clear_pin_n_i,
  output var  logic                  master_clear_pin_o,
  output var  logic                  master_clear_pin_oe,
  input  wire logic                  watchdog_timeout,
  input  wire logic                  sleep_active,
  input  wire logic                  oscillator_input_pin,
  output var  logic                  chip_reset_q,
  output var  logic                  core_hold_q,
  output var  logic                  wake_pulse_q
);

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration register
  logic [3:0]    cfg_q;
  rstseq_osc_t   osc_mode;
  logic          pud_on;
  logic          xtal;
  logic          brownout_en;

  assign osc_mode    = rstseq_osc_t'(cfg_q[CFG_OSC_LSB +: 2]);
  assign xtal        = rstseq_is_crystal(osc_mode);
  assign brownout_en = cfg_q[CFG_BOD_BIT];
  // Brown-out forces the delay on, whatever the enable bit says
  assign pud_on      = !cfg_q[CFG_PUD_N_BIT] || brownout_en;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin conditioning
  logic clear_filt;
  logic clear_prev_q;
  logic brownout_filt;
  logic osc_prev_q;
  logic osc_rise;

  rstseq_filter #(.CYCLES(CLEAR_FILT_CYCLES)) u_clear_filt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .raw     (!master_clear_pin_n_i),
    .filt_q  (clear_filt)
  );

  rstseq_filter #(.CYCLES(BROWNOUT_MIN_CYCLES)) u_brown_filt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .raw     (brownout_below && brownout_en),
    .filt_q  (brownout_filt)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clear_prev_q <= 1'b0;
      osc_prev_q   <= 1'b0;
    end
    else
    begin
      clear_prev_q <= clear_filt;
      osc_prev_q   <= oscillator_input_pin;
    end
  end

  assign osc_rise = oscillator_input_pin && !osc_prev_q;

  // Pin is input only here: watchdog resets never reach the board
  assign master_clear_pin_o  = 1'b0;
  assign master_clear_pin_oe = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Internal oscillator tick and timers
  logic [INTOSC_DIV_W-1:0] div_q;
  logic                    intosc_tick;
  rstseq_state_t           state_q;
  rstseq_state_t           state_d;
  logic                    pud_done;
  logic                    osu_done;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || intosc_tick)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  assign intosc_tick = div_q == INTOSC_DIV_W'(INTOSC_DIV_CYCLES - 1);

  // Cleared outside its state, so re-entry always restarts the full delay
  rstseq_timer #(.LIMIT(PUD_TICKS_P)) u_pud (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (state_q != S_PUD),
    .step    (intosc_tick),
    .done_q  (pud_done)
  );

  rstseq_timer #(.LIMIT(OSU_CYCLES)) u_osu (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (state_q != S_OSU && state_q != S_WAKE),
    .step    (osc_rise),
    .done_q  (osu_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Reset events
  rstseq_cause_t cause_q;
  logic          por_ev;
  logic          brown_ev;
  logic          clear_ev;
  logic          wdt_reset_ev;
  logic          wake_ev;

  assign por_ev       = state_q == S_OFF && por_detect;
  assign brown_ev     = brownout_filt && por_detect && state_q != S_OFF
                        && state_q != S_BROWNOUT;
  assign clear_ev     = clear_filt && !clear_prev_q;
  assign wdt_reset_ev = watchdog_timeout && state_q == S_RUN && !sleep_active;
  assign wake_ev      = watchdog_timeout && state_q == S_RUN && sleep_active;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb
  begin
    state_d = state_q;
    if (!por_detect)
      state_d = S_OFF;
    else if (brownout_filt && state_q != S_OFF)
      state_d = S_BROWNOUT;
    else
    begin
      unique case (state_q)
        S_OFF:
          state_d = pud_on ? S_PUD : (xtal ? S_OSU : S_RUN);
        S_BROWNOUT:
          state_d = S_PUD;
        S_PUD:
          if (pud_done)
            state_d = (xtal && cause_q == CAUSE_POWER_ON) ? S_OSU : S_RUN;
        S_OSU, S_WAKE:
          if (osu_done)
            state_d = S_RUN;
        S_RUN:
          if (wake_ev && xtal)
            state_d = S_WAKE;
        default:
          state_d = S_OFF;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_q <= S_OFF;
    else
      state_q <= state_d;
  end

  // Timers run regardless of the clear pin; the pin only adds its own reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      chip_reset_q <= 1'b1;
      core_hold_q  <= 1'b1;
      wake_pulse_q <= 1'b0;
    end
    else
    begin
      chip_reset_q <= (state_d != S_RUN && state_d != S_WAKE)
                      || clear_filt || wdt_reset_ev;
      core_hold_q  <= state_d != S_RUN || clear_filt || wdt_reset_ev;
      wake_pulse_q <= wake_ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Cause and status flags
  logic wdx_flag_q;
  logic sleep_flag_q;
  logic por_flag_q;
  logic brown_flag_q;
  logic sw_set_por;
  logic sw_set_brown;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || por_ev)
    begin
      wdx_flag_q   <= 1'b1;
      sleep_flag_q <= 1'b1;
      cause_q      <= CAUSE_POWER_ON;
    end
    else if (brown_ev)
    begin
      wdx_flag_q   <= 1'b1;
      sleep_flag_q <= 1'b1;
      cause_q      <= CAUSE_BROWNOUT;
    end
    else if (clear_ev)
    begin
      cause_q <= sleep_active ? CAUSE_CLEAR_SLEEP : CAUSE_CLEAR_RUN;
      if (sleep_active)
      begin
        wdx_flag_q   <= 1'b1;
        sleep_flag_q <= 1'b0;
      end
    end
    else if (wdt_reset_ev)
    begin
      wdx_flag_q   <= 1'b0;
      sleep_flag_q <= 1'b1;
      cause_q      <= CAUSE_WATCHDOG_RESET;
    end
    else if (wake_ev)
    begin
      wdx_flag_q   <= 1'b0;
      sleep_flag_q <= 1'b0;
      cause_q      <= CAUSE_WATCHDOG_WAKE;
    end
  end

  // Hardware clear beats a software set in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      por_flag_q   <= 1'b0;
      brown_flag_q <= 1'b0;
    end
    else if (por_ev)
    begin
      por_flag_q   <= 1'b0;
      brown_flag_q <= brownout_en ? 1'b1 : brown_flag_q;
    end
    else
    begin
      por_flag_q   <= por_flag_q || sw_set_por;
      brown_flag_q <= brown_ev ? 1'b0 : (brown_flag_q || sw_set_brown);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic                  aw_hold_q;
  logic                  w_hold_q;
  logic [AXI_ADDR_W-1:0] awaddr_q;
  logic [AXI_DATA_W-1:0] wdata_q;
  logic [3:0]            wstrb_q;
  logic                  do_write;
  rstseq_sel_t           wsel;
  logic [AXI_DATA_W-1:0] status_word;

  assign awready  = !aw_hold_q && !bvalid;
  assign wready   = !w_hold_q && !bvalid;
  assign arready  = !rvalid;
  assign do_write = aw_hold_q && w_hold_q && !bvalid;
  assign wsel     = rstseq_decode(awaddr_q);

  assign sw_set_por   = do_write && wsel == SEL_STATUS && wstrb_q[0] && wdata_q[ST_POR_BIT];
  assign sw_set_brown = do_write && wsel == SEL_STATUS && wstrb_q[0] && wdata_q[ST_BROWN_BIT];

  always_comb
  begin
    status_word                       = '0;
    status_word[ST_WDX_BIT]           = wdx_flag_q;
    status_word[ST_SLEEP_BIT]         = sleep_flag_q;
    status_word[ST_POR_BIT]           = por_flag_q;
    status_word[ST_BROWN_BIT]         = brown_flag_q;
    status_word[ST_CAUSE_LSB +: 3]    = cause_q;
    status_word[ST_HOLD_BIT]          = core_hold_q;
    status_word[ST_RESET_BIT]         = chip_reset_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= awaddr;
      end
      else if (do_write)
        aw_hold_q <= 1'b0;
      if (wvalid && wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
      end
      else if (do_write)
        w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_q <= CFG_RESET;
    else if (do_write && wsel == SEL_CONFIG && wstrb_q[0])
      cfg_q <= wdata_q[3:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp  <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      unique case (rstseq_decode(araddr))
        SEL_CONFIG:
        begin
          rdata <= {28'h0000000, cfg_q};
          rresp <= RESP_OKAY;
        end
        SEL_STATUS:
        begin
          rdata <= status_word;
          rresp <= RESP_OKAY;
        end
        default:
        begin
          rdata <= '0;
          rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_pud_expire;
    state_q == S_PUD && pud_done && por_detect && !brownout_filt;
  endsequence

  sequence s_por_start;
    por_ev && !brownout_filt;
  endsequence

  chk_por_flags_set: assert property (
    por_ev |=> !por_flag_q && wdx_flag_q && sleep_flag_q && cause_q == CAUSE_POWER_ON)
    else $error("power-on flags wrong");

  chk_brown_flag_clr: assert property (
    brown_ev && !por_ev |=> !brown_flag_q && cause_q == CAUSE_BROWNOUT)
    else $error("brown-out flag not cleared");

  chk_clear_filter: assert property (
    $rose(clear_filt) |-> $past(!master_clear_pin_n_i, CLEAR_FILT_CYCLES))
    else $error("short clear pulse passed filter");

  chk_pud_hold: assert property (
    state_q == S_PUD |-> chip_reset_q)
    else $error("reset released during power-up delay");

  chk_wdt_internal: assert property (
    wdt_reset_ev && !clear_ev && !brown_ev
    |=> chip_reset_q && !master_clear_pin_oe && cause_q == CAUSE_WATCHDOG_RESET)
    else $error("watchdog reset handling wrong");

  chk_wake_no_reset: assert property (
    wake_ev && !clear_filt && !brownout_filt && por_detect |=> !chip_reset_q && wake_pulse_q)
    else $error("watchdog wake reset registers");

  chk_brown_restart: assert property (
    state_q == S_PUD && brownout_filt && por_detect |=> state_q == S_BROWNOUT ##1 !pud_done)
    else $error("brown-out did not restart delay");

  chk_brown_recover: assert property (
    state_q == S_BROWNOUT && !brownout_filt && por_detect |=> state_q == S_PUD)
    else $error("no power-up delay after brown-out");

  chk_no_timeout: assert property (
    s_por_start ##0 (osc_mode == OSC_RES_CAP && !pud_on) |=> state_q == S_RUN)
    else $error("time-out applied in resistor-capacitor mode");

  chk_osu_follows: assert property (
    s_pud_expire ##0 (xtal && cause_q == CAUSE_POWER_ON) |=> state_q == S_OSU)
    else $error("start-up count did not follow delay");

  chk_osu_skipped: assert property (
    s_pud_expire ##0 (cause_q != CAUSE_POWER_ON) |=> state_q == S_RUN)
    else $error("start-up count not skipped");

  chk_clear_stretch: assert property (
    clear_filt |=> chip_reset_q)
    else $error("clear pin did not hold reset");

endmodule // rstseq_top
`default_nettype wire

// file: verif/rstseq_board.sv
// Purpose: Supply monitors and crystal seen from the sequencer pins
// Assumes: Bench steers supply level and dips
// Notes:   Crystal runs free at half the core rate
`timescale 1ns/1ps
`default_nettype none
module rstseq_board
(
  input  wire logic aclk,
  input  wire logic supply_on,
  input  wire logic supply_dip,
  output var  logic por_detect,
  output var  logic brownout_below,
  output var  logic oscillator_input_pin
);
  // Level detectors, no hysteresis modelled
  assign por_detect     = supply_on;
  assign brownout_below = supply_dip;
  initial oscillator_input_pin = 1'b0;
  always @(posedge aclk)
    oscillator_input_pin <= ~oscillator_input_pin;
endmodule // rstseq_board
`default_nettype wire

// file: verif/reset_and_startup_sequencer_bench.sv
// Purpose: Self-checking bench of the reset and start-up sequencer
// Assumes: Power-up delay shortened to 120 ticks, still longer than the brown-out filter
// Notes:   Counts get bounds since the tick phase is free
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
  begin samples_checked++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module reset_and_startup_sequencer_bench
  import rstseq_pkg::*;
;
  typedef struct {logic [3:0] c; int lo; int hi;} rstseq_row_t;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0, sup_on = 1'b0;
  logic        dip = 1'b0, clr_n = 1'b1, wdt = 1'b0, slp = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, st;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid, cr, ch, wk_p, oe, mo;
  logic        por_detect, brownout_below, oscillator_input_pin;
  logic        seen = 1'b0, hs = 1'b0, wk = 1'b0, drv = 1'b0;
  int          errors = 0, samples_checked = 0, n;
  rstseq_row_t rows [6] = '{'{4'h3, 1192, 1201}, '{4'h7, 0, 4}, '{4'h4, 2040, 2070},
                            '{4'h1, 3240, 3250}, '{4'h2, 3240, 3250}, '{4'h8, 3240, 3250}};

  always #50 aclk = ~aclk;
  always @(posedge aclk)
  begin
    if (cr) seen <= 1'b1;
    if (ch) hs <= 1'b1;
    if (wk_p) wk <= 1'b1;
    if (oe) drv <= 1'b1;
  end

  rstseq_board board (.aclk, .supply_on(sup_on), .supply_dip(dip), .por_detect,
    .brownout_below, .oscillator_input_pin);
  rstseq_top #(.PUD_TICKS_P(120)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .por_detect,
    .brownout_below, .master_clear_pin_n_i(clr_n), .master_clear_pin_o(mo),
    .master_clear_pin_oe(oe), .watchdog_timeout(wdt), .sleep_active(slp),
    .oscillator_input_pin, .chip_reset_q(cr), .core_hold_q(ch), .wake_pulse_q(wk_p));

  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] q);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Channels drop independently, each at its own take
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      ad = ad | awready;
      wd = wd | wready;
    end
    while (!bvalid) @(posedge aclk);
    q = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] q);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    q = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rel(output int k);
    k = 0;
    while (cr !== 1'b0 && k < 4000)
    begin
      cyc(1);
      k++;
    end
  endtask

  task automatic powerup(input logic [3:0] c, output int k);
    aresetn <= 1'b0;
    sup_on <= 1'b0;
    cyc(5);
    aresetn <= 1'b1;
    cyc(1);
    wr(ADDR_CONFIG, {28'h0, c}, r);
    sup_on <= 1'b1;
    cyc(2);
    rel(k);
  endtask

  task automatic wrap_up();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(60000);
    errors++;
    wrap_up();
  end

  initial
  begin
    foreach (rows[i])
    begin
      powerup(rows[i].c, n);
      `CHK(n >= rows[i].lo && n <= rows[i].hi, 1'b1)
      rd(ADDR_STATUS, st, r);
      `CHK(st[6:0] & 7'h77, 7'h03)
    end
    aresetn <= 1'b0;
    sup_on <= 1'b0;
    cyc(5);
    aresetn <= 1'b1;
    cyc(1);
    rd(ADDR_CONFIG, st, r);
    `CHK(st, 32'h0000000F)
    rd(ADDR_STATUS, st, r);
    `CHK(st, 32'h00000183)
    rd(4'h8, st, r);
    `CHK({st, r}, {32'h0, RESP_SLVERR})
    wr(4'hC, 32'h1, r);
    `CHK(r, RESP_SLVERR)
    powerup(4'h8, n);
    wr(ADDR_STATUS, 32'h0000000C, r);
    `CHK(r, RESP_OKAY)
    seen = 1'b0;
    clr_n <= 1'b0;
    cyc(4);
    clr_n <= 1'b1;
    cyc(4);
    `CHK(seen, 1'b0)
    clr_n <= 1'b0;
    cyc(8);
    `CHK(cr, 1'b1)
    clr_n <= 1'b1;
    cyc(3);
    `CHK(cr, 1'b0)
    rd(ADDR_STATUS, st, r);
    `CHK(st[6:0], 7'h1F)
    seen = 1'b0;
    wdt <= 1'b1;
    cyc(1);
    wdt <= 1'b0;
    cyc(3);
    `CHK(seen, 1'b1)
    rd(ADDR_STATUS, st, r);
    `CHK(st[6:0], 7'h3E)
    seen = 1'b0;
    hs = 1'b0;
    slp <= 1'b1;
    wdt <= 1'b1;
    cyc(1);
    wdt <= 1'b0;
    slp <= 1'b0;
    cyc(2200);
    `CHK({seen, hs, wk}, 3'b011)
    rd(ADDR_STATUS, st, r);
    `CHK(st[6:0], 7'h4C)
    seen = 1'b0;
    dip <= 1'b1;
    cyc(500);
    dip <= 1'b0;
    cyc(5);
    `CHK(seen, 1'b0)
    dip <= 1'b1;
    cyc(1100);
    `CHK(cr, 1'b1)
    cyc(300);
    `CHK(cr, 1'b1)
    // Second dip lands inside the delay to force a restart
    dip <= 1'b0;
    cyc(20);
    dip <= 1'b1;
    cyc(1010);
    dip <= 1'b0;
    rel(n);
    `CHK(n >= 1195 && n <= 1204, 1'b1)
    rd(ADDR_STATUS, st, r);
    `CHK(st[6:2], 5'h15)
    clr_n <= 1'b0;
    sup_on <= 1'b0;
    cyc(2);
    sup_on <= 1'b1;
    cyc(3400);
    clr_n <= 1'b1;
    cyc(3);
    `CHK(cr, 1'b0)
    `CHK(drv, 1'b0)
    `CHK(mo, 1'b0)
    wrap_up();
  end
endmodule // reset_and_startup_sequencer_bench
`default_nettype wire
